// ### hw/svdc_pkg.sv
// Constants, types and register map for the serial voltage code controller.
package svdc_pkg;
  localparam int ADC_W = 10;
  localparam int NSRC = 9;
  localparam int NPH = 2;
  localparam int IRQ_W = 10;
  localparam int LIM_W = 26;
  // Code zero is 1.55 V and each step lowers the setpoint by 6.25 mV.
  localparam int UV_AT_CODE_ZERO = 1550000;
  localparam int UV_PER_STEP = 6250;
  localparam logic [7:0] CODE_ZERO_V = 8'(UV_AT_CODE_ZERO / UV_PER_STEP);
  localparam logic [7:0] CODE_OFF_MIN = 8'hF9;
  localparam logic [7:0] CODE_RST = 8'hFF;
  localparam int CLK_NS = 25;
  localparam int SLEW_STEP_NS = 1000;
  localparam int SLEW_CYC = (SLEW_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_GAP_NS = 2000;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_BITS = 9;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_CORE = 8'h0C;
  localparam logic [7:0] A_AUX = 8'h10;
  localparam logic [7:0] A_ONTIME = 8'h14;
  localparam logic [7:0] A_LIMIT = 8'h18;
  localparam logic [7:0] A_ADC = 8'h1C;
  localparam logic [7:0] A_STATE = 8'h20;
  // Reset values.
  localparam logic [7:0] ONTIME_RST = 8'h20;
  localparam logic [LIM_W-1:0] LIMIT_RST = 26'h3001010;
  localparam logic [3:0] SRC_RST = 4'h0;
  // ADC multiplexer sources.
  localparam logic [3:0] SRC_STRAP1 = 4'h0;
  localparam logic [3:0] SRC_STRAP2 = 4'h1;
  localparam logic [3:0] SRC_STRAP3 = 4'h2;
  localparam logic [3:0] SRC_OFS_CORE = 4'h3;
  localparam logic [3:0] SRC_OFS_AUX = 4'h4;
  localparam logic [3:0] SRC_CORE_CURRENT_MONITOR_CORE = 4'h5;
  localparam logic [3:0] SRC_CORE_CURRENT_MONITOR_AUX = 4'h6;
  localparam logic [3:0] SRC_CORE_VOLTAGE_SENSE_CORE = 4'h7;
  localparam logic [3:0] SRC_CORE_VOLTAGE_SENSE_AUX = 4'h8;

  typedef struct packed {
    logic oc;
    logic ov;
    logic uv;
    logic nv;
  } rail_fault_t;

  typedef struct packed {
    logic [ADC_W-1:0] oc_limit;
    logic [7:0] uv_margin;
    logic [7:0] ov_margin;
  } limits_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_SOFT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_FAULT = 4'b1000
  } ctl_state_t;
endpackage

// ### hw/rail_channel.sv
// One rail: code decode, reference slew, on-time pulses and fault checks.
`timescale 1ns/1ps
module rail_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic step_tick,
  input wire logic [7:0] code,
  input wire logic [7:0] ontime_base,
  input wire svdc_pkg::limits_t limits,
  // Sense
  input wire logic [9:0] vsense,
  input wire logic [9:0] isense,
  input wire logic [19:0] phase_cur,
  input wire logic [1:0] trig,
  // Results
  output logic [7:0] ref_lvl,
  output logic rail_off,
  output logic at_target,
  output svdc_pkg::rail_fault_t fault,
  output logic [1:0] ontime
);
  localparam int W = svdc_pkg::ADC_W;
  logic [7:0] target;
  logic [7:0] ref_q;
  logic [W:0] vs;
  logic [W:0] hi;
  logic [W:0] lo;
  logic [W:0] cur_sum;
  logic [W-1:0] avg;
  svdc_pkg::rail_fault_t fault_d;
  svdc_pkg::rail_fault_t fault_q;

  // ==========================================================
  // Code decode and reference slew.
  assign rail_off = (code >= svdc_pkg::CODE_OFF_MIN);
  assign target = rail_off ? 8'h00 : 8'(svdc_pkg::CODE_ZERO_V - code);
  assign at_target = (ref_q == target);
  assign ref_lvl = ref_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 8'h00;
    end else if (clr) begin
      ref_q <= 8'h00;
    end else if (run && step_tick && !at_target) begin
      ref_q <= (ref_q < target) ? ref_q + 8'h01 : ref_q - 8'h01;
    end
  end

  // ==========================================================
  // Fault checks.
  assign vs = {1'b0, vsense};
  assign hi = {3'h0, ref_q} + {3'h0, limits.ov_margin};
  assign lo = vs + {3'h0, limits.uv_margin};
  assign fault_d.nv = vsense[W-1];
  assign fault_d.ov = !vsense[W-1] && (vs > hi);
  assign fault_d.uv = !vsense[W-1] && (lo < {3'h0, ref_q});
  assign fault_d.oc = (isense > limits.oc_limit);
  assign fault = fault_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 4'h0;
    end else begin
      fault_q <= (run && !clr) ? fault_d : 4'h0;
    end
  end

  // ==========================================================
  // On-time pulses trimmed by current balance.
  assign cur_sum = {1'b0, phase_cur[0 +: W]} + {1'b0, phase_cur[W +: W]};
  assign avg = cur_sum[W:1];

  for (genvar p = 0; p < svdc_pkg::NPH; p++) begin : g_ph
    logic signed [W+1:0] diff;
    logic signed [W+1:0] len;
    logic [W+1:0] len_c;
    logic [W+1:0] cnt_q;
    assign diff = $signed({2'h0, avg}) - $signed({2'h0, phase_cur[p*W +: W]});
    assign len = $signed({4'h0, ontime_base}) + (diff >>> 2);
    assign len_c = (len < 12'sh001) ? 12'h001 : len;
    assign ontime[p] = (cnt_q != 12'h000);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= 12'h000;
      end else if (clr || !run) begin
        cnt_q <= 12'h000;
      end else if (trig[p] && cnt_q == 12'h000) begin
        cnt_q <= len_c;
      end else if (cnt_q != 12'h000) begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

  property p_decode;
    @(posedge clk) disable iff (!rst_n)
      at_target && !rail_off |-> 8'(ref_lvl + code) == svdc_pkg::CODE_ZERO_V;
  endproperty
  a_decode: assert property (p_decode) else $error("decode wrong");

  property p_off;
    @(posedge clk) disable iff (!rst_n)
      at_target && code >= 8'hF9 |-> rail_off && ref_lvl == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("off code wrong");

  property p_slew;
    @(posedge clk) disable iff (!rst_n)
      !$past(clr) && ref_q != $past(ref_q) |->
        $past(step_tick) && (ref_q == $past(ref_q) + 8'h01 ||
        ref_q == $past(ref_q) - 8'h01);
  endproperty
  a_slew: assert property (p_slew) else $error("reference jumped");

  property p_ontime;
    @(posedge clk) disable iff (!rst_n)
      run && !clr && trig[0] && !ontime[0] |=>
        g_ph[0].cnt_q == $past(g_ph[0].len_c);
  endproperty
  a_ontime: assert property (p_ontime) else $error("on-time wrong");
endmodule // rail_channel

// ### hw/serial_vid_decode_control.sv
// Serial voltage code controller: link, sequencing, indicators and APB.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Code zero 1.55 V, 6.25 mV per step.
// - One of nine sources steered to ADC.
// - Serial clock, data, telemetry carry processor commands.
// - Supply lockout blocks regulation and holds reset.
// - Soft-start on enable; indicators after soft-start.
// - Over-current event in run state pulls indicator low until off.
// - Decoded codes form core and aux references.
// - Reference steps toward target; only lockout clears it to zero.
// - Per-phase on-time from setting plus trim.
// - Phase current error lengthens or shortens on-time.
// - Rails checked for OC, OV, UV, NV.
// - Over-current indicator is open drain, low only.
module serial_vid_decode_control (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial voltage link
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data,
  output logic serial_telemetry,
  // Platform
  input wire logic enable_in,
  input wire logic supply_lockout,
  // ADC multiplexer
  output logic [3:0] adc_mux_sel,
  input wire logic adc_valid,
  input wire logic [9:0] adc_result,
  // Rails
  input wire logic [19:0] core_phase_cur,
  input wire logic [19:0] aux_phase_cur,
  input wire logic [1:0] core_pwm_trigger,
  input wire logic [1:0] aux_pwm_trigger,
  output logic [7:0] core_reference,
  output logic [7:0] aux_reference,
  output logic core_rail_off,
  output logic aux_rail_off,
  output logic [1:0] core_ontime_gen,
  output logic [1:0] aux_ontime_gen,
  // Open-drain indicators
  output logic core_power_good_out,
  output logic core_power_good_oe,
  output logic aux_power_good_out,
  output logic aux_power_good_oe,
  output logic overcurrent_flag_n_out,
  output logic overcurrent_flag_n_oe,
  // Interrupt
  output logic irq
);
  localparam int GAP_W = $clog2(svdc_pkg::FRAME_GAP_CYC + 1);
  localparam int SLW_W = $clog2(svdc_pkg::SLEW_CYC + 1);
  localparam int IW = svdc_pkg::IRQ_W;

  // ==========================================================
  // Input synchronisers.
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic sclk_s;
  logic sdata_s;
  logic en_s;
  logic lock_s;
  logic [1:0] core_trig_s;
  logic [1:0] aux_trig_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {aux_pwm_trigger, core_pwm_trigger, supply_lockout,
                  enable_in, serial_vid_data, serial_vid_clock};
      sync2_q <= sync1_q;
    end
  end
  assign {aux_trig_s, core_trig_s, lock_s, en_s, sdata_s, sclk_s} = sync2_q;

  // ==========================================================
  // Serial frame receiver: rail bit, then code MSB first.
  logic sclk_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [GAP_W-1:0] gap_q;
  logic [7:0] core_code_q;
  logic [7:0] aux_code_q;
  logic sclk_rise;
  logic frame_done;
  logic gap_out;
  logic [7:0] rx_code;

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign gap_out = (gap_q == GAP_W'(svdc_pkg::FRAME_GAP_CYC));
  assign frame_done = sclk_rise &&
                      (bit_cnt_q == 4'(svdc_pkg::FRAME_BITS - 1));
  assign rx_code = {shift_q[6:0], sdata_s};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= 1'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      gap_q <= '0;
    end else begin
      sclk_prev_q <= sclk_s;
      shift_q <= sclk_rise ? {shift_q[6:0], sdata_s} : shift_q;
      gap_q <= sclk_rise ? '0 : (gap_out ? gap_q : gap_q + 1'b1);
      if (frame_done || (gap_out && !sclk_rise) || lock_s) begin
        bit_cnt_q <= 4'h0;
      end else if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_code_q <= svdc_pkg::CODE_RST;
      aux_code_q <= svdc_pkg::CODE_RST;
    end else if (lock_s) begin
      core_code_q <= svdc_pkg::CODE_RST;
      aux_code_q <= svdc_pkg::CODE_RST;
    end else if (frame_done && !shift_q[7]) begin
      core_code_q <= rx_code;
    end else if (frame_done) begin
      aux_code_q <= rx_code;
    end
  end

  // ==========================================================
  // APB registers.
  logic [3:0] sel_q;
  logic [IW-1:0] status_q;
  logic [IW-1:0] mask_q;
  logic [7:0] ontime_q;
  svdc_pkg::limits_t lim_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic [9:0] adc_store_q [svdc_pkg::NSRC];
  logic access;
  logic hit;
  logic wr;
  logic [IW-1:0] clr_mask;
  logic [IW-1:0] events;
  svdc_pkg::rail_fault_t core_flt;
  svdc_pkg::rail_fault_t aux_flt;
  svdc_pkg::ctl_state_t state_q;
  svdc_pkg::ctl_state_t state_d;
  logic ss_done;

  assign access = psel && penable;
  assign hit = (paddr == svdc_pkg::A_CTRL) || (paddr == svdc_pkg::A_STATUS) ||
               (paddr == svdc_pkg::A_MASK) || (paddr == svdc_pkg::A_CORE) ||
               (paddr == svdc_pkg::A_AUX) || (paddr == svdc_pkg::A_ONTIME) ||
               (paddr == svdc_pkg::A_LIMIT) || (paddr == svdc_pkg::A_ADC) ||
               (paddr == svdc_pkg::A_STATE);
  assign wr = access && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_q;
  assign clr_mask = (access && !pwrite && paddr == svdc_pkg::A_STATUS) ?
                    prdata_q[IW-1:0] : '0;
  assign events = {frame_done, ss_done, aux_flt, core_flt};
  assign irq = |(status_q & mask_q);
  assign adc_mux_sel = sel_q;
  assign rdata_d =
    (paddr == svdc_pkg::A_CTRL) ? 32'(sel_q) :
    (paddr == svdc_pkg::A_STATUS) ? 32'(status_q) :
    (paddr == svdc_pkg::A_MASK) ? 32'(mask_q) :
    (paddr == svdc_pkg::A_CORE) ?
      32'({core_rail_off, core_reference, core_code_q}) :
    (paddr == svdc_pkg::A_AUX) ?
      32'({aux_rail_off, aux_reference, aux_code_q}) :
    (paddr == svdc_pkg::A_ONTIME) ? 32'(ontime_q) :
    (paddr == svdc_pkg::A_LIMIT) ? 32'(lim_q) :
    (paddr == svdc_pkg::A_ADC) ? 32'({sel_q, 2'h0, adc_store_q[sel_q]}) :
    (paddr == svdc_pkg::A_STATE) ? 32'({serial_telemetry, state_q}) :
    32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= svdc_pkg::SRC_RST;
      mask_q <= '0;
      ontime_q <= svdc_pkg::ONTIME_RST;
      lim_q <= svdc_pkg::LIMIT_RST;
    end else if (wr) begin
      if (paddr == svdc_pkg::A_CTRL && pwdata[3:0] <= svdc_pkg::SRC_CORE_VOLTAGE_SENSE_AUX)
        sel_q <= pwdata[3:0];
      if (paddr == svdc_pkg::A_MASK) mask_q <= pwdata[IW-1:0];
      if (paddr == svdc_pkg::A_ONTIME) ontime_q <= pwdata[7:0];
      if (paddr == svdc_pkg::A_LIMIT) lim_q <= pwdata[svdc_pkg::LIM_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr_mask) | events;
    end
  end

  always_ff @(posedge pclk) begin
    if (adc_valid) adc_store_q[sel_q] <= adc_result;
  end

  // ==========================================================
  // Sequencing state machine.
  logic step_tick;
  logic [SLW_W-1:0] slew_q;
  logic run;
  logic core_at;
  logic aux_at;
  logic any_oc;
  logic oc_hold_q;
  logic pg_core_q;
  logic pg_aux_q;
  logic tele_q;

  assign step_tick = (slew_q == SLW_W'(svdc_pkg::SLEW_CYC - 1));
  assign run = !lock_s && (state_q == svdc_pkg::ST_SOFT ||
               state_q == svdc_pkg::ST_RUN);
  assign any_oc = core_flt.oc || aux_flt.oc;
  assign ss_done = (state_q == svdc_pkg::ST_SOFT) &&
                   (state_d == svdc_pkg::ST_RUN);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      svdc_pkg::ST_OFF: if (en_s) state_d = svdc_pkg::ST_SOFT;
      svdc_pkg::ST_SOFT: begin
        if (!en_s) state_d = svdc_pkg::ST_OFF;
        else if (core_at && aux_at) state_d = svdc_pkg::ST_RUN;
      end
      svdc_pkg::ST_RUN: begin
        if (!en_s) state_d = svdc_pkg::ST_OFF;
        else if (|core_flt || |aux_flt) state_d = svdc_pkg::ST_FAULT;
      end
      svdc_pkg::ST_FAULT: if (!en_s) state_d = svdc_pkg::ST_OFF;
    endcase
    if (lock_s) state_d = svdc_pkg::ST_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= svdc_pkg::ST_OFF;
      slew_q <= '0;
    end else begin
      state_q <= state_d;
      slew_q <= step_tick ? '0 : slew_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_hold_q <= 1'b0;
      pg_core_q <= 1'b0;
      pg_aux_q <= 1'b0;
      tele_q <= 1'b0;
    end else begin
      oc_hold_q <= (state_q == svdc_pkg::ST_RUN && any_oc) ||
                   (oc_hold_q && state_q != svdc_pkg::ST_OFF);
      pg_core_q <= (state_q == svdc_pkg::ST_RUN) && !(|core_flt);
      pg_aux_q <= (state_q == svdc_pkg::ST_RUN) && !(|aux_flt);
      tele_q <= (state_q == svdc_pkg::ST_RUN);
    end
  end

  assign serial_telemetry = tele_q;
  assign core_power_good_out = 1'b0;
  assign aux_power_good_out = 1'b0;
  assign core_power_good_oe = !pg_core_q;
  assign aux_power_good_oe = !pg_aux_q;
  assign overcurrent_flag_n_out = 1'b0;
  assign overcurrent_flag_n_oe = oc_hold_q;

  // ==========================================================
  // Rail channels.
  rail_channel u_core (
    .clk(pclk), .rst_n(presetn), .clr(lock_s), .run(run),
    .step_tick(step_tick), .code(core_code_q), .ontime_base(ontime_q),
    .limits(lim_q), .vsense(adc_store_q[svdc_pkg::SRC_CORE_VOLTAGE_SENSE_CORE]),
    .isense(adc_store_q[svdc_pkg::SRC_CORE_CURRENT_MONITOR_CORE]),
    .phase_cur(core_phase_cur), .trig(core_trig_s),
    .ref_lvl(core_reference), .rail_off(core_rail_off),
    .at_target(core_at), .fault(core_flt), .ontime(core_ontime_gen)
  );

  rail_channel u_aux (
    .clk(pclk), .rst_n(presetn), .clr(lock_s), .run(run),
    .step_tick(step_tick), .code(aux_code_q), .ontime_base(ontime_q),
    .limits(lim_q), .vsense(adc_store_q[svdc_pkg::SRC_CORE_VOLTAGE_SENSE_AUX]),
    .isense(adc_store_q[svdc_pkg::SRC_CORE_CURRENT_MONITOR_AUX]),
    .phase_cur(aux_phase_cur), .trig(aux_trig_s),
    .ref_lvl(aux_reference), .rail_off(aux_rail_off),
    .at_target(aux_at), .fault(aux_flt), .ontime(aux_ontime_gen)
  );

  property p_lockout;
    @(posedge pclk) disable iff (!presetn)
      lock_s |=> state_q == svdc_pkg::ST_OFF && core_code_q == 8'hFF;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout ignored");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      state_q == svdc_pkg::ST_OFF && en_s && !lock_s |=>
        state_q == svdc_pkg::ST_SOFT;
  endproperty
  a_start: assert property (p_start) else $error("no soft-start");

  property p_core_power_good;
    @(posedge pclk) disable iff (!presetn)
      !core_power_good_oe |-> $past(state_q) == svdc_pkg::ST_RUN;
  endproperty
  a_core_power_good: assert property (p_core_power_good) else $error("early power good");

  property p_ocp;
    @(posedge pclk) disable iff (!presetn)
      state_q == svdc_pkg::ST_RUN && any_oc |=> overcurrent_flag_n_oe [*2];
  endproperty
  a_ocp: assert property (p_ocp) else $error("over-current missed");

  property p_opendrain;
    @(posedge pclk) disable iff (!presetn)
      overcurrent_flag_n_oe |-> !overcurrent_flag_n_out;
  endproperty
  a_opendrain: assert property (p_opendrain) else $error("drove high");

  property p_frame;
    @(posedge pclk) disable iff (!presetn)
      frame_done && !lock_s && !shift_q[7] |=>
        core_code_q == $past(rx_code) && $stable(aux_code_q);
  endproperty
  a_frame: assert property (p_frame) else $error("core code lost");

  property p_aux_frame;
    @(posedge pclk) disable iff (!presetn)
      frame_done && !lock_s && shift_q[7] |=>
        aux_code_q == $past(rx_code) && $stable(core_code_q);
  endproperty
  a_aux_frame: assert property (p_aux_frame) else $error("aux code lost");

  property p_adc;
    @(posedge pclk) disable iff (!presetn)
      adc_valid |=> adc_store_q[$past(sel_q)] == $past(adc_result);
  endproperty
  a_adc: assert property (p_adc) else $error("sample not stored");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      |(events & mask_q) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missed");
endmodule // serial_vid_decode_control

// ### tb/vid_host_model.sv
// Host side model that sends voltage code frames on the serial link.
`timescale 1ns/1ps
module vid_host_model (
  // Serial voltage link
  output logic serial_vid_clock,
  output logic serial_vid_data
);
  initial begin
    serial_vid_clock = 1'b0;
    serial_vid_data = 1'b0;
  end
  // Sends the rail bit, then the code with its top bit first.
  task automatic send(input logic rail, input logic [7:0] code);
    logic [8:0] frame;
    frame = {rail, code};
    // Moves off the sampling edge of the block's clock.
    #5;
    for (int i = 8; i >= 0; i--) begin
      serial_vid_data = frame[i];
      #100 serial_vid_clock = 1'b1;
      #100 serial_vid_clock = 1'b0;
    end
    // The clock rests low and the data line shows a stale inverse.
    serial_vid_data = ~frame[0];
  endtask
endmodule // vid_host_model

// ### tb/serial_vid_decode_control_test.sv
// Self-checking bench for the serial voltage code controller.
`timescale 1ns/1ps
module serial_vid_decode_control_test;
  // ==========
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic enable_in = 1'b0;
  logic supply_lockout = 1'b0;
  logic adc_valid = 1'b0;
  logic [9:0] adc_result = 10'h000;
  logic [19:0] core_phase_cur = 20'h00000;
  logic [1:0] core_pwm_trigger = 2'b00;
  logic [1:0] aux_pwm_trigger = 2'b00;
  int aux_len = 0;
  logic [9:0] smp;
  logic [31:0] prdata;
  logic pready, pslverr, serial_telemetry, irq;
  logic serial_vid_clock, serial_vid_data;
  logic [3:0] adc_mux_sel;
  logic [7:0] core_reference, aux_reference;
  logic core_rail_off, aux_rail_off;
  logic [1:0] core_ontime_gen, aux_ontime_gen;
  logic core_power_good_out, core_power_good_oe;
  logic aux_power_good_out, aux_power_good_oe;
  logic overcurrent_flag_n_out, overcurrent_flag_n_oe;
  int errors = 0;
  int checked = 0;
  int run_len = 0;
  int p0[3] = '{0, 40, 20};
  int ln[3] = '{13, 3, 8};
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int len_q[$];
  logic [31:0] seed = 32'hEA2A1EAA;
  logic [31:0] mv;
  logic [7:0] c1, c2;

  always #12.5 pclk = ~pclk;

  serial_vid_decode_control DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_vid_clock, .serial_vid_data,
    .serial_telemetry, .enable_in, .supply_lockout, .adc_mux_sel,
    .adc_valid, .adc_result, .core_phase_cur, .aux_phase_cur(20'h00000),
    .core_pwm_trigger, .aux_pwm_trigger, .core_reference,
    .aux_reference, .core_rail_off, .aux_rail_off, .core_ontime_gen,
    .aux_ontime_gen, .core_power_good_out, .core_power_good_oe,
    .aux_power_good_out, .aux_power_good_oe, .overcurrent_flag_n_out,
    .overcurrent_flag_n_oe, .irq
  );
  vid_host_model host (.serial_vid_clock, .serial_vid_data);

  // ==========
  // Checking
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected code register word: off flag, reference, code.
  function automatic logic [32:0] rail_word(input logic [7:0] c);
    return 33'({c >= 8'hF9, (c >= 8'hF9) ? 8'h00 : 8'hF8 - c, c});
  endfunction

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Read results are compared when the access completes.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      mv = msk_q.pop_front();
      cmp({pslverr, prdata & mv}, exp_q.pop_front());
    end
  end

  // On-time pulse lengths are measured on phase zero.
  always @(posedge pclk) begin
    if (core_ontime_gen[0] === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      cmp(33'(run_len), 33'(len_q.pop_front()));
      run_len <= 0;
    end
  end

  // Aux phase zero sees balanced currents, so its pulse is the base.
  always @(posedge pclk) begin
    if (aux_ontime_gen[0] === 1'b1) begin
      aux_len <= aux_len + 1;
    end else if (aux_len != 0) begin
      cmp(33'(aux_len), 33'h8);
      aux_len <= 0;
    end
  end

  initial begin
    #200000;
    errors++;
    close_out();
  end

  // ==========
  // Stimulus
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(svdc_pkg::A_ONTIME, 33'h20, 32'hFFFFFFFF);
    rd(svdc_pkg::A_LIMIT, 33'h3001010, 32'hFFFFFFFF);
    rd(svdc_pkg::A_CORE, 33'h100FF, 32'h1FFFF);
    rd(8'h24, 33'h100000000, 32'hFFFFFFFF);
    for (int s = 0; s < 10; s++) begin
      apb(1'b1, svdc_pkg::A_CTRL, 32'(s));
      cmp(33'(adc_mux_sel), 33'((s > 8) ? 8 : s));
    end
    apb(1'b1, svdc_pkg::A_MASK, 32'h200);
    for (int i = 8'hF6; i <= 8'hFF; i++) begin
      host.send(1'b0, 8'(i));
      repeat (6) @(posedge pclk);
      cmp(33'(irq), 33'h1);
      rd(svdc_pkg::A_STATUS, 33'h200, 32'h200);
      cmp(33'(irq), 33'h0);
      rd(svdc_pkg::A_CORE, 33'({i >= 8'hF9, 8'h00, 8'(i)}), 32'h1FFFF);
      cmp(33'(core_rail_off), 33'(i >= 8'hF9));
    end
    c1 = 8'hF0 | 8'(rnd() & 32'h7);
    c2 = 8'hF0 | 8'(rnd() & 32'h7);
    host.send(1'b0, c1);
    host.send(1'b1, c2);
    repeat (6) @(posedge pclk);
    rd(svdc_pkg::A_STATE, 33'h01, 32'h1F);
    for (int s = 5; s <= 8; s++) begin
      apb(1'b1, svdc_pkg::A_CTRL, 32'(s));
      smp = 10'(rnd() & 32'hF);
      adc_result <= smp;
      adc_valid <= 1'b1;
      @(posedge pclk);
      adc_valid <= 1'b0;
      rd(svdc_pkg::A_ADC, 33'((s << 12) | smp), 32'hF3FF);
    end
    enable_in <= 1'b1;
    repeat (30) @(posedge pclk);
    cmp(33'(core_reference > 8'h01), 33'h0);
    for (int i = 0; i < 800 && core_power_good_oe !== 1'b0; i++)
      @(posedge pclk);
    cmp(33'(core_power_good_oe), 33'h0);
    cmp(33'(serial_telemetry), 33'h1);
    cmp(33'(aux_rail_off), 33'h0);
    rd(svdc_pkg::A_CORE, rail_word(c1), 32'h1FFFF);
    rd(svdc_pkg::A_AUX, rail_word(c2), 32'h1FFFF);
    rd(svdc_pkg::A_STATE, 33'h14, 32'h1F);
    cmp(33'(aux_power_good_oe), 33'h0);
    cmp(33'(overcurrent_flag_n_oe), 33'h0);
    apb(1'b1, svdc_pkg::A_ONTIME, 32'h8);
    for (int k = 0; k < 3; k++) begin
      core_phase_cur <= {10'(40 - p0[k]), 10'(p0[k])};
      len_q.push_back(ln[k]);
      repeat (4) @(posedge pclk);
      core_pwm_trigger <= 2'b01;
      aux_pwm_trigger <= 2'b01;
      repeat (4) @(posedge pclk);
      core_pwm_trigger <= 2'b00;
      aux_pwm_trigger <= 2'b00;
      repeat (30) @(posedge pclk);
    end
    apb(1'b1, svdc_pkg::A_CTRL, 32'(svdc_pkg::SRC_CORE_CURRENT_MONITOR_CORE));
    adc_result <= {2'b11, 8'(rnd() | 32'h1)};
    adc_valid <= 1'b1;
    @(posedge pclk);
    adc_valid <= 1'b0;
    repeat (10) @(posedge pclk);
    cmp(33'(overcurrent_flag_n_oe), 33'h1);
    cmp(33'(overcurrent_flag_n_out), 33'h0);
    cmp(33'(core_power_good_oe), 33'h1);
    rd(svdc_pkg::A_STATUS, 33'h8, 32'h8);
    supply_lockout <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(svdc_pkg::A_STATE, 33'h01, 32'h1F);
    rd(svdc_pkg::A_CORE, 33'h100FF, 32'h1FFFF);
    cmp(33'(overcurrent_flag_n_oe), 33'h0);
    close_out();
  end
endmodule // serial_vid_decode_control_test
